// ### pkg/fcm_pkg.sv
/*
  Constants shared by the fieldbus/CANopen master control block.
  Assumes a 100 MHz core clock and a byte-wide fieldbus data image.
*/
// Function
// - Rising edge of control bit 5 sends a remote request to every receive PDO.
// - Gateway error byte is placed at a configured fieldbus data position.
// - Service-data record sits at configured request and response window indices.
// - Master starts each job; done when response job number equals request's.
// - Window indices count from zero, index zero is the first byte.
// - Record: index hi, index lo, sub-index, command/status, job, node, length, data.
// - Long replies are truncated; otherwise the real received length is reported.
// - Slave mode skips only the master start-up broadcast.
// - Configured node address applies only while the address switch reads zero.
// - Cycle period in milliseconds sets the SYNC interval.
// - Cycle period zero disables SYNC generation.
// - In start phase, broadcast start-remote-nodes every two seconds.
// - First mapped PDO received ends the start phase.
// - The start phase has no timeout.
// - Toggling control bit 6 re-sends the operational command, only during cyclic data exchange.
// - Any change of control bit 6 sends the set-operational message; the code sends it only for a change between two bytes of cyclic data exchange.
// - Mapped data is exchanged only in fieldbus cyclic data-exchange state.
package fcm_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned START_PERIOD_MS = 2000;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;
  localparam int unsigned START_PERIOD_CYC = START_PERIOD_MS * CYCLES_PER_MS;
  localparam int unsigned BIT_RTR = 5;
  localparam int unsigned BIT_GO_OP = 6;
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam int unsigned REC_IDX_HI = 0;
  localparam int unsigned REC_IDX_LO = 1;
  localparam int unsigned REC_SUB = 2;
  localparam int unsigned REC_CMD = 3;
  localparam int unsigned REC_JOB = 4;
  localparam int unsigned REC_NODE = 5;
  localparam int unsigned REC_LEN = 6;
  localparam int unsigned REC_DATA = 7;
  localparam int unsigned MAX_RX_PDO = 50;
endpackage

// ### pkg/fcm_sdo_if.sv
/*
  Interface between the control core and the service-data window engine.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface fcm_sdo_if;
  logic active;
  logic [7:0] req_job;
  logic [7:0] rsp_job;
  logic start;
  logic busy;
  modport core (output active, req_job, input rsp_job, start, busy);
  modport engine (input active, req_job, output rsp_job, start, busy);
endinterface
`default_nettype wire

// ### hdl/fcm_sdo_engine.sv
/*
  Service-data job tracker: decides when a new job starts and echoes the
  job number once the CAN side reports completion.
  Assumes the CAN transfer engine outside answers with sdo_done.
*/
`timescale 1ns/1ps
`default_nettype none
module fcm_sdo_engine (
  input wire logic core_clk,
  input wire logic reset,
  fcm_sdo_if.engine sif,
  input wire logic sdo_done
);
  typedef enum logic [0:0] {FCM_IDLE, FCM_BUSY} fcm_sdo_state_t;
  typedef struct packed {
    fcm_sdo_state_t st;
    logic [7:0] echo;
    logic start;
  } fcm_sdo_t;
  fcm_sdo_t s, next_s;

  always_comb begin
    next_s = s;
    next_s.start = 1'b0;
    unique case (s.st)
      FCM_IDLE: begin
        // New job only on a fresh job number
        if (sif.active && sif.req_job != s.echo) begin
          next_s.start = 1'b1;
          next_s.st = FCM_BUSY;
        end
      end
      FCM_BUSY: begin
        if (sdo_done) begin
          next_s.echo = sif.req_job;
          next_s.st = FCM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s <= '{st: FCM_IDLE, echo: 8'h00, start: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign sif.rsp_job = s.echo;
  assign sif.start = s.start;
  assign sif.busy = (s.st == FCM_BUSY);
endmodule
`default_nettype wire

// ### hdl/fcm_master_ctrl.sv
/*
  Control core of the fieldbus to CANopen master gateway: control byte
  events, start phase broadcast, SYNC timing, node address, error byte
  and service-data window placement.
  Assumes fieldbus bytes arrive as a byte-addressed image on the core clock,
  the address switch is an asynchronous pin, and CAN framing is outside.
*/
`timescale 1ns/1ps
`default_nettype none
module fcm_master_ctrl #(
  parameter int unsigned START_PERIOD_CYC = fcm_pkg::START_PERIOD_CYC,
  parameter int unsigned MS_CYC = fcm_pkg::CYCLES_PER_MS,
  parameter int unsigned RX_PDO_CNT = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic data_exchange,
  input wire logic [7:0] control_byte,
  input wire logic slave_mode,
  input wire logic [6:0] cfg_node_address,
  input wire logic [6:0] address_switch,
  input wire logic [15:0] cycle_period_ms,
  input wire logic mapped_pdo_rx,
  input wire logic [7:0] gw_error_status,
  input wire logic [7:0] error_byte_index,
  input wire logic [7:0] request_window_index,
  input wire logic [7:0] response_window_index,
  input wire logic [7:0] fb_in_byte,
  input wire logic [7:0] rsp_status,
  input wire logic [7:0] rsp_data,
  input wire logic [7:0] rx_len,
  input wire logic sdo_done,
  output logic [7:0] fb_in_addr,
  output logic fb_out_we,
  output logic [7:0] fb_out_addr,
  output logic [7:0] fb_out_byte,
  output logic rtr_send,
  output logic [5:0] rtr_pdo,
  output logic start_remote_nodes_cmd,
  output logic go_operational_send,
  output logic sync_send,
  output logic [6:0] node_address,
  output logic start_phase,
  output logic sdo_start,
  output logic sdo_busy,
  output logic [7:0] job_number,
  output logic [7:0] target_node_field,
  output logic [15:0] sdo_object_index,
  output logic [7:0] sdo_sub_index,
  output logic [7:0] sdo_req_len
);
  typedef struct packed {
    logic [2:0][6:0] sw_sync;
    logic [6:0] sw_stable;
    logic [7:0] ctl_prev;
    logic ctl_valid;
    logic rtr_run;
    logic [5:0] rtr_idx;
    logic [31:0] start_cnt;
    logic in_start;
    logic [31:0] ms_cnt;
    logic [15:0] ms_total;
    logic [2:0] scan;
    logic [7:0] req_job;
    logic [7:0] out_slot;
    logic [7:0] fb_in_addr;
    logic fb_out_we;
    logic [7:0] fb_out_addr;
    logic [7:0] fb_out_byte;
    logic rtr_send;
    logic [5:0] rtr_pdo;
    logic start_cmd;
    logic go_op;
    logic sync_send;
    logic [6:0] node_address;
    logic [7:0] node_f;
    logic [15:0] obj;
    logic [7:0] sub;
    logic [7:0] len;
    logic sdo_start;
    logic sdo_busy;
    logic [7:0] job_echo;
  } fcm_state_t;
  fcm_state_t s, next_s;

  fcm_sdo_if sif ();

  fcm_sdo_engine u_sdo (
    .core_clk(core_clk),
    .reset(reset),
    .sif(sif),
    .sdo_done(sdo_done)
  );

  assign sif.active = data_exchange;
  assign sif.req_job = s.req_job;

  // Reported length is the smaller of request and received
  function automatic logic [7:0] fcm_min(input logic [7:0] a, input logic [7:0] b);
    fcm_min = (a < b) ? a : b;
  endfunction

  always_comb begin
    next_s = s;
    next_s.rtr_send = 1'b0;
    next_s.start_cmd = 1'b0;
    next_s.go_op = 1'b0;
    next_s.sync_send = 1'b0;
    next_s.fb_out_we = 1'b0;
    next_s.sw_sync = {s.sw_sync[1:0], address_switch};
    if (s.sw_sync[2] == s.sw_sync[1]) begin
      next_s.sw_stable = s.sw_sync[2];
    end
    // Switch wins unless it reads zero
    next_s.node_address = (s.sw_stable == 7'h00) ? cfg_node_address : s.sw_stable;

    // Job tracker flags pass one more register so outputs leave flip-flops
    next_s.sdo_start = sif.start;
    next_s.sdo_busy = sif.busy;
    next_s.job_echo = sif.rsp_job;

    // One request per receive PDO, walked by index
    if (s.rtr_run) begin
      next_s.rtr_send = 1'b1;
      next_s.rtr_pdo = s.rtr_idx;
      if (32'(s.rtr_idx) + 1 >= RX_PDO_CNT) begin
        next_s.rtr_run = 1'b0;
      end else begin
        next_s.rtr_idx = s.rtr_idx + 6'h01;
      end
    end
    // Control byte edges count only while the fieldbus is cyclic
    // Placed after the walk so a fresh edge restarts it even on its last step
    if (data_exchange) begin
      next_s.ctl_prev = control_byte;
      next_s.ctl_valid = 1'b1;
      if (s.ctl_valid) begin
        if (control_byte[fcm_pkg::BIT_RTR] && !s.ctl_prev[fcm_pkg::BIT_RTR]) begin
          next_s.rtr_run = 1'b1;
          next_s.rtr_idx = 6'h00;
        end
        if (control_byte[fcm_pkg::BIT_GO_OP] != s.ctl_prev[fcm_pkg::BIT_GO_OP]) begin
          next_s.go_op = 1'b1;
        end
      end
    end else begin
      // History is stale after a pause, so the next cyclic byte only primes it
      next_s.ctl_valid = 1'b0;
    end

    // Start phase: no timeout, only a mapped PDO ends it
    if (s.in_start) begin
      if (mapped_pdo_rx) begin
        next_s.in_start = 1'b0;
      end else if (s.start_cnt == 32'(START_PERIOD_CYC - 1)) begin
        next_s.start_cnt = 32'h0;
        next_s.start_cmd = !slave_mode;
      end else begin
        next_s.start_cnt = s.start_cnt + 32'h1;
      end
    end

    // SYNC interval in milliseconds, zero disables it
    if (cycle_period_ms == 16'h0000) begin
      next_s.ms_cnt = 32'h0;
      next_s.ms_total = 16'h0000;
    end else if (s.ms_cnt == 32'(MS_CYC - 1)) begin
      next_s.ms_cnt = 32'h0;
      if (s.ms_total + 16'h0001 >= cycle_period_ms) begin
        next_s.ms_total = 16'h0000;
        next_s.sync_send = 1'b1;
      end else begin
        next_s.ms_total = s.ms_total + 16'h0001;
      end
    end else begin
      next_s.ms_cnt = s.ms_cnt + 32'h1;
    end

    // Round-robin scan: fetch request record, write response and error byte
    next_s.scan = s.scan + 3'h1;
    next_s.fb_in_addr = request_window_index + 8'(s.scan);
    if (data_exchange) begin
      unique case (s.scan - 3'h2)
        3'(fcm_pkg::REC_IDX_HI): next_s.obj[15:8] = fb_in_byte;
        3'(fcm_pkg::REC_IDX_LO): next_s.obj[7:0] = fb_in_byte;
        3'(fcm_pkg::REC_SUB): next_s.sub = fb_in_byte;
        3'(fcm_pkg::REC_JOB): next_s.req_job = fb_in_byte;
        3'(fcm_pkg::REC_NODE): next_s.node_f = fb_in_byte;
        3'(fcm_pkg::REC_LEN): next_s.len = fb_in_byte;
        default: next_s.len = s.len;
      endcase
      next_s.fb_out_we = 1'b1;
      next_s.out_slot = s.out_slot + 8'h01;
      next_s.fb_out_addr = response_window_index + s.out_slot;
      unique case (s.out_slot)
        8'(fcm_pkg::REC_IDX_HI): next_s.fb_out_byte = s.obj[15:8];
        8'(fcm_pkg::REC_IDX_LO): next_s.fb_out_byte = s.obj[7:0];
        8'(fcm_pkg::REC_SUB): next_s.fb_out_byte = s.sub;
        8'(fcm_pkg::REC_CMD): next_s.fb_out_byte = rsp_status;
        8'(fcm_pkg::REC_JOB): next_s.fb_out_byte = sif.rsp_job;
        8'(fcm_pkg::REC_NODE): next_s.fb_out_byte = s.node_f;
        8'(fcm_pkg::REC_LEN): next_s.fb_out_byte = fcm_min(s.len, rx_len);
        8'(fcm_pkg::REC_DATA): next_s.fb_out_byte = rsp_data;
        default: begin
          // Error byte slot closes each pass
          next_s.fb_out_addr = error_byte_index;
          next_s.fb_out_byte = gw_error_status;
          next_s.out_slot = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s <= '0;
      s.in_start <= 1'b1;
      s.node_address <= 7'h00;
    end else begin
      s <= next_s;
    end
  end

  assign fb_in_addr = s.fb_in_addr;
  assign fb_out_we = s.fb_out_we;
  assign fb_out_addr = s.fb_out_addr;
  assign fb_out_byte = s.fb_out_byte;
  assign rtr_send = s.rtr_send;
  assign rtr_pdo = s.rtr_pdo;
  assign start_remote_nodes_cmd = s.start_cmd;
  assign go_operational_send = s.go_op;
  assign sync_send = s.sync_send;
  assign node_address = s.node_address;
  assign start_phase = s.in_start;
  assign target_node_field = s.node_f;
  assign sdo_object_index = s.obj;
  assign sdo_sub_index = s.sub;
  assign sdo_req_len = s.len;
  assign sdo_start = s.sdo_start;
  assign sdo_busy = s.sdo_busy;
  assign job_number = s.job_echo;
endmodule
`default_nettype wire

// ### verification/fcm_ctrl_props.sv
/* Port checker for the master control core.
   Assumes the bind hands on the shortened start period and PDO count. */
`timescale 1ns/1ps
`default_nettype none
module fcm_ctrl_props #(
  parameter int unsigned START_PERIOD_CYC = 100,
  parameter int unsigned RX_PDO_CNT = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic data_exchange,
  input wire logic [7:0] control_byte,
  input wire logic slave_mode,
  input wire logic [6:0] cfg_node_address,
  input wire logic [6:0] address_switch,
  input wire logic [15:0] cycle_period_ms,
  input wire logic mapped_pdo_rx,
  input wire logic sdo_done,
  input wire logic rtr_send,
  input wire logic [5:0] rtr_pdo,
  input wire logic start_remote_nodes_cmd,
  input wire logic go_operational_send,
  input wire logic sync_send,
  input wire logic [6:0] node_address,
  input wire logic start_phase,
  input wire logic sdo_start,
  input wire logic sdo_busy
);
  int unsigned gap;
  logic seen;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Slave mode breaks the pulse train, so spacing is judged only after a fresh pulse
  always_ff @(posedge core_clk) begin
    gap <= start_remote_nodes_cmd ? 0 : gap + 1;
    seen <= !(reset || slave_mode) && (seen || start_remote_nodes_cmd);
  end
  // An edge counts only once the history was primed in exchange state
  sequence s_live;
    data_exchange && $past(data_exchange) && !$past(reset);
  endsequence
  a_rtr_start: assert property (s_live ##0 $rose(control_byte[5]) |-> ##2 rtr_send && rtr_pdo == 6'h00)
    else $error("remote request walk did not start");
  a_rtr_walk: assert property (rtr_send && rtr_pdo != 6'(RX_PDO_CNT - 1)
    |=> rtr_send && (rtr_pdo == $past(rtr_pdo) + 6'h01 || rtr_pdo == 6'h00))
    else $error("remote request walk broken");
  a_go_change: assert property (s_live ##0 $changed(control_byte[6]) |=> go_operational_send)
    else $error("toggle change not sent");
  a_go_cause: assert property (go_operational_send
    |-> $past(data_exchange) && $past(control_byte[6]) != $past(control_byte[6], 2))
    else $error("operational message without toggle change");
  a_start_gap: assert property (start_remote_nodes_cmd && seen |-> gap == START_PERIOD_CYC - 1)
    else $error("start broadcast spacing off");
  a_slave_quiet: assert property (slave_mode && $past(slave_mode) |-> !start_remote_nodes_cmd)
    else $error("start broadcast in slave mode");
  a_phase_exit: assert property (mapped_pdo_rx |=> !start_phase ##1 !start_remote_nodes_cmd)
    else $error("start phase kept after mapped data");
  a_node_pick: assert property ((!reset && $stable(address_switch) && $stable(cfg_node_address))[*7]
    |-> node_address == (address_switch == 7'h00 ? cfg_node_address : address_switch))
    else $error("node address source wrong");
  a_sync_off: assert property ((cycle_period_ms == 16'h0000)[*3] |-> !sync_send)
    else $error("sync sent while disabled");
  a_sdo_hold: assert property (sdo_start ##1 !sdo_done |-> sdo_busy && !sdo_start)
    else $error("job not held busy");
endmodule
bind fcm_master_ctrl fcm_ctrl_props #(.START_PERIOD_CYC(START_PERIOD_CYC),
  .RX_PDO_CNT(RX_PDO_CNT)) props (
  .core_clk(core_clk),
  .reset(reset),
  .data_exchange(data_exchange),
  .control_byte(control_byte),
  .slave_mode(slave_mode),
  .cfg_node_address(cfg_node_address),
  .address_switch(address_switch),
  .cycle_period_ms(cycle_period_ms),
  .mapped_pdo_rx(mapped_pdo_rx),
  .sdo_done(sdo_done),
  .rtr_send(rtr_send),
  .rtr_pdo(rtr_pdo),
  .start_remote_nodes_cmd(start_remote_nodes_cmd),
  .go_operational_send(go_operational_send),
  .sync_send(sync_send),
  .node_address(node_address),
  .start_phase(start_phase),
  .sdo_start(sdo_start),
  .sdo_busy(sdo_busy)
);
`default_nettype wire

// ### verification/fcm_far_side.sv
/* Far side model: master data images and a CAN service-data responder.
   Assumes reads are answered one cycle after the address. */
`timescale 1ns/1ps
`default_nettype none
module fcm_far_side (
  input wire logic core_clk,
  input wire logic [7:0] fb_in_addr,
  input wire logic fb_out_we,
  input wire logic [7:0] fb_out_addr,
  input wire logic [7:0] fb_out_byte,
  input wire logic sdo_start,
  input wire logic [7:0] reply_len,
  input wire logic [3:0] reply_delay,
  output logic [7:0] fb_in_byte,
  output logic [7:0] rsp_status,
  output logic [7:0] rsp_data,
  output logic [7:0] rx_len,
  output logic sdo_done
);
  logic [7:0] req_img [256];
  logic [7:0] rsp_img [256];
  int wait_cnt = -1;
  initial begin
    foreach (req_img[i]) req_img[i] = 8'h00;
    fb_in_byte = 8'h00;
    sdo_done = 1'b0;
  end
  always @(posedge core_clk) begin
    fb_in_byte <= req_img[fb_in_addr];
    if (fb_out_we) rsp_img[fb_out_addr] <= fb_out_byte;
    sdo_done <= (wait_cnt == 0); // Reply only after a job was started
    if (sdo_start) wait_cnt <= int'(reply_delay);
    else if (wait_cnt >= 0) wait_cnt <= wait_cnt - 1;
  end
  assign rsp_status = fcm_pkg::STATUS_OK;
  assign rsp_data = 8'h5a;
  assign rx_len = reply_len;
endmodule
`default_nettype wire

// ### verification/fieldbus_canopen_master_control_test.sv
/* Bench for the master control core with the far side model.
   Assumes start period 100 cycles and 10 cycles per millisecond. */
`timescale 1ns/1ps
`default_nettype none
module fieldbus_canopen_master_control_test;
  localparam int unsigned RX_PDO_CNT = 4; // Within one to fifty
  logic core_clk = 1'b0, reset = 1'b1, data_exchange = 1'b0, slave_mode = 1'b0;
  logic mapped_pdo_rx = 1'b0, fb_out_we, rtr_send, start_remote_nodes_cmd, go_operational_send;
  logic sync_send, start_phase, sdo_start, sdo_busy, sdo_done;
  logic [7:0] control_byte = 8'h00, gw_error_status = 8'h00, error_byte_index = 8'h30;
  logic [7:0] request_window_index = 8'h00, response_window_index = 8'h10, reply_len = 8'h00;
  logic [7:0] rsp_status, rsp_data, rx_len, fb_in_byte, fb_in_addr, fb_out_addr, fb_out_byte;
  logic [7:0] job_number, target_node_field, sdo_sub_index, sdo_req_len;
  logic [6:0] cfg_node_address = 7'h11, address_switch = 7'h00, node_address;
  logic [15:0] cycle_period_ms = 16'h0003, sdo_object_index;
  logic [5:0] rtr_pdo;
  logic [3:0] reply_delay = 4'h2;
  int n_fail = 0, n_tests = 0, cyc = 0, tot[5] = '{default: 0}, base[5];
  fcm_master_ctrl #(.START_PERIOD_CYC(100), .MS_CYC(10), .RX_PDO_CNT(RX_PDO_CNT)) uut (.*);
  fcm_far_side far (.*);
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    tot <= '{tot[0] + start_remote_nodes_cmd, tot[1] + sync_send, tot[2] + rtr_send,
      tot[3] + go_operational_send, tot[4] + sdo_start};
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic span(int n);
    base = tot;
    repeat (n) @(posedge core_clk);
  endtask
  function automatic int d(int k);
    return tot[k] - base[k];
  endfunction
  function automatic logic [7:0] rsp(int unsigned k);
    return far.rsp_img[8'h10 + k];
  endfunction
  task automatic run_job(logic [7:0] jn, logic [7:0] rl, logic [7:0] rxl, logic [3:0] dl);
    logic [15:0] obj;
    logic [7:0] sub;
    int k;
    obj = 16'($urandom);
    sub = 8'($urandom);
    far.req_img[2] <= sub;
    reply_len <= rxl;
    reply_delay <= dl;
    far.req_img[0] <= obj[15:8]; // Window index zero is the first byte
    far.req_img[1] <= obj[7:0];
    far.req_img[3] <= fcm_pkg::CMD_READ;
    far.req_img[5] <= 8'h05;
    far.req_img[6] <= rl; // Room sized by the master
    far.req_img[4] <= jn;
    base = tot;
    for (k = 0; k < 400 && rsp(fcm_pkg::REC_JOB) !== jn; k++) @(posedge core_clk);
    repeat (10) @(posedge core_clk);
    check("job echo", jn, rsp(fcm_pkg::REC_JOB));
    check("status", fcm_pkg::STATUS_OK, rsp(fcm_pkg::REC_CMD));
    check("length", (rl < rxl) ? rl : rxl, rsp(fcm_pkg::REC_LEN));
    check("data", 8'h5a, rsp(fcm_pkg::REC_DATA));
    check("object", obj, sdo_object_index);
    check("node field", 8'h05, target_node_field);
    check("sub index", sub, sdo_sub_index);
    check("request len", rl, sdo_req_len);
    check("job number", jn, job_number);
    check("job starts", 1, d(4));
  endtask
  initial begin
    logic [7:0] cb;
    logic [6:0] sw;
    int k;
    void'($urandom(32'hf77d));
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    data_exchange <= 1'b1;
    gw_error_status <= 8'($urandom);
    span(50);
    span(300);
    check("start pulses", 3, d(0));
    check("sync pulses", 10, d(1));
    check("still starting", 1, start_phase);
    check("error byte", gw_error_status, far.rsp_img[8'h30]);
    slave_mode <= 1'b1;
    span(2);
    span(300);
    check("slave starts", 0, d(0));
    check("slave syncs", 10, d(1));
    slave_mode <= 1'b0;
    cycle_period_ms <= 16'h0000;
    span(5);
    span(300);
    check("sync off", 0, d(1));
    mapped_pdo_rx <= 1'b1;
    @(posedge core_clk);
    mapped_pdo_rx <= 1'b0;
    span(300);
    check("late starts", 0, d(0));
    control_byte <= 8'h20;
    span(20);
    check("rtr pulses", RX_PDO_CNT, d(2));
    data_exchange <= 1'b0;
    control_byte <= 8'h00;
    @(posedge core_clk);
    control_byte <= 8'h60;
    span(20);
    check("idle rtr", 0, d(2) + d(3));
    data_exchange <= 1'b1;
    span(3);
    k = 0;
    for (int i = 0; i < 40; i++) begin
      cb = 8'($urandom);
      k += int'(cb[6] != control_byte[6]);
      control_byte <= cb;
      @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
    check("op pulses", k, d(3));
    for (int i = 0; i < 5; i++) begin
      sw = (i == 0) ? 7'h00 : 7'($urandom_range(127, 1));
      cb = 8'($urandom);
      address_switch <= sw;
      cfg_node_address <= cb[6:0];
      repeat (8) @(posedge core_clk);
      check("node", (sw == 7'h00) ? cb[6:0] : sw, node_address);
    end
    run_job(8'h01, 8'h02, 8'h03, 4'h2);
    run_job(8'h02, 8'h05, 8'h03, 4'hc);
    span(60);
    check("no restart", 0, d(4));
    finish_test();
  end
endmodule
`default_nettype wire
